// >>> common/anticoll_pkg.sv
// Package for the tag anticollision state machine: decoded commands, states, carriers.
// Assumes a frame decoder upstream delivers one decoded command per pulse.
package anticoll_pkg;
  localparam int ID_W = 8;
  localparam int SLOT_W = 4;
  localparam logic [15:0] LFSR_SEED_DEFAULT = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  localparam logic [ID_W-1:0] ID_RESET = 8'h00;
  localparam logic [SLOT_W-1:0] SLOT_ZERO = 4'h0;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_START_INV,
    CMD_SLOT_ZERO,
    CMD_SLOT_ADV,
    CMD_CHOOSE,
    CMD_COMPLETE
  } cmd_code_t;

  typedef enum {
    ST_READY,
    ST_INVENTORY,
    ST_SELECTED,
    ST_DESELECTED,
    ST_DEACTIVATED
  } tag_state_t;

  typedef struct packed {
    cmd_code_t code;
    logic [SLOT_W-1:0] slot_number_param;
    logic [ID_W-1:0] id_param;
  } cmd_t;

  typedef struct packed {
    logic valid;
    logic [ID_W-1:0] session_tag_number;
  } answer_t;
endpackage

// >>> hdl/rand_source.sv
// Free-running Galois LFSR giving the tag's random values.
// Assumes each tag gets a distinct seed at integration, so tags differ.
`timescale 1ns/10ps
module rand_source #(
  parameter logic [15:0] SEED = anticoll_pkg::LFSR_SEED_DEFAULT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Random word
  output logic [15:0] rnd
);
  logic [15:0] lfsr_r;
  logic [15:0] lfsr_nxt;
  assign lfsr_nxt = lfsr_r[0] ? ((lfsr_r >> 1) ^ anticoll_pkg::LFSR_TAPS) : (lfsr_r >> 1);
  assign rnd = lfsr_r;

  // Reset to a per-tag seed; never zero so it cannot lock up
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lfsr_r <= (SEED == 16'h0000) ? anticoll_pkg::LFSR_SEED_DEFAULT : SEED;
    end else begin
      lfsr_r <= lfsr_nxt;
    end
  end
endmodule

// >>> hdl/tag_anticollision_sequence.sv
// Tag side of the slotted anticollision protocol: state and session identifier.
// Assumes decoded commands arrive as one-cycle pulses on core_clk; rstn is power-up in field.
//
// How it works
// - Slot commands answered only in inventory
// - Ready tag waits for start-inventory first
// - Power-up loads random session identifier
// - Start-inventory in ready or inventory: new id, inventory, answer
// - Slot nibble is identifier's low four bits
// - Slot-zero call rerolls nibble, answers on zero
// - Slot advance answers when number matches nibble
// - Matching choose moves inventory to selected
`timescale 1ns/10ps
module tag_anticollision_sequence #(
  parameter logic [15:0] SEED = anticoll_pkg::LFSR_SEED_DEFAULT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Decoded command from the frame receiver
  input wire logic cmd_valid,
  input wire anticoll_pkg::cmd_t cmd,
  // Answer to the frame transmitter
  output anticoll_pkg::answer_t answer,
  // Status
  output logic [2:0] tag_state,
  output logic [anticoll_pkg::ID_W-1:0] session_tag_number
);
  localparam int IW = anticoll_pkg::ID_W;
  localparam int SW = anticoll_pkg::SLOT_W;

  logic [15:0] rnd;
  anticoll_pkg::tag_state_t state_r;
  anticoll_pkg::tag_state_t state_nxt;
  logic [IW-1:0] id_r;
  logic [IW-1:0] id_nxt;
  logic seeded_r;
  anticoll_pkg::answer_t ans_r;
  anticoll_pkg::answer_t ans_nxt;

  rand_source #(.SEED(SEED)) u_rand (
    .core_clk(core_clk),
    .rstn(rstn),
    .rnd(rnd)
  );

  wire in_inv = (state_r == anticoll_pkg::ST_INVENTORY);
  wire is_start = cmd_valid && (cmd.code == anticoll_pkg::CMD_START_INV);
  wire is_zero = cmd_valid && (cmd.code == anticoll_pkg::CMD_SLOT_ZERO) && in_inv;
  wire is_adv = cmd_valid && (cmd.code == anticoll_pkg::CMD_SLOT_ADV) && in_inv;
  wire is_choose = cmd_valid && (cmd.code == anticoll_pkg::CMD_CHOOSE);
  wire is_compl = cmd_valid && (cmd.code == anticoll_pkg::CMD_COMPLETE);
  wire id_match = (cmd.id_param == id_r);
  wire [SW-1:0] new_nibble = rnd[SW-1:0];
  wire [SW-1:0] slot_nibble = id_r[SW-1:0];
  wire start_ok = is_start && (state_r == anticoll_pkg::ST_READY
                               || state_r == anticoll_pkg::ST_INVENTORY);
  wire [IW-1:0] new_id = rnd[15:8] ^ rnd[IW-1:0];

  always_comb begin
    state_nxt = state_r;
    id_nxt = id_r;
    ans_nxt = '0;
    if (!seeded_r) begin
      id_nxt = new_id;
    end else if (start_ok) begin
      id_nxt = new_id;
      state_nxt = anticoll_pkg::ST_INVENTORY;
      ans_nxt.valid = 1'b1;
      ans_nxt.session_tag_number = new_id;
    end else if (is_zero) begin
      id_nxt = {id_r[IW-1:SW], new_nibble};
      ans_nxt.valid = (new_nibble == anticoll_pkg::SLOT_ZERO);
      ans_nxt.session_tag_number = {id_r[IW-1:SW], new_nibble};
    end else if (is_adv) begin
      ans_nxt.valid = (cmd.slot_number_param == slot_nibble);
      ans_nxt.session_tag_number = id_r;
    end else if (is_choose) begin
      case (state_r)
        anticoll_pkg::ST_INVENTORY: begin
          if (id_match) begin
            state_nxt = anticoll_pkg::ST_SELECTED;
          end
        end
        anticoll_pkg::ST_SELECTED: begin
          if (!id_match) begin
            state_nxt = anticoll_pkg::ST_DESELECTED;
          end
        end
        anticoll_pkg::ST_DESELECTED: begin
          if (id_match) begin
            state_nxt = anticoll_pkg::ST_SELECTED;
          end
        end
        default: begin
          state_nxt = state_r;
        end
      endcase
    end else if (is_compl && state_r == anticoll_pkg::ST_SELECTED) begin
      state_nxt = anticoll_pkg::ST_DEACTIVATED;
    end
  end

  // Power-up in the field lands in ready; id filled one cycle later from the source
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= anticoll_pkg::ST_READY;
      id_r <= anticoll_pkg::ID_RESET;
      seeded_r <= 1'b0;
      ans_r <= '0;
    end else begin
      state_r <= state_nxt;
      id_r <= id_nxt;
      seeded_r <= 1'b1;
      ans_r <= ans_nxt;
    end
  end

  assign answer = ans_r;
  assign session_tag_number = id_r;
  assign tag_state = 3'(state_r);
endmodule

// >>> verif/tag_anticollision_sequence_assertions.sv
// Port checker for the tag block.
// Assumes one clock, rstn synchronous active low.
`timescale 1ns/10ps
module tag_anticollision_sequence_assertions (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire anticoll_pkg::cmd_t cmd,
  input wire anticoll_pkg::answer_t answer,
  input wire logic [2:0] tag_state,
  input wire logic [7:0] session_tag_number
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Codes follow cmd_code_t order
  wire [2:0] op = cmd_valid ? cmd.code : 3'h0;
  wire inv = tag_state == 3'h1;
  wire own = cmd.id_param == session_tag_number;
  chk_slot_gate: assert property (op > 3'h1 && op < 3'h4 && !inv
    |=> !answer.valid) else $error("slot gate");
  chk_ready_wait: assert property (tag_state == 3'h0 && op > 3'h1
    |=> tag_state == 3'h0) else $error("ready left");
  chk_start_ans: assert property ($past(rstn) && tag_state < 3'h2 && op == 3'h1
    |=> inv && answer.valid && answer.session_tag_number == session_tag_number)
    else $error("start answer");
  chk_zero_call: assert property (inv && op == 3'h2
    |=> answer.valid == (session_tag_number[3:0] == 4'h0)) else $error("zero call");
  chk_slot_match: assert property (inv && op == 3'h3
    |=> answer.valid == ($past(cmd.slot_number_param) == session_tag_number[3:0]))
    else $error("slot match");
  chk_choose_hit: assert property (inv && op == 3'h4 && own
    |=> tag_state == 3'h2 && !answer.valid) else $error("choose hit");
  chk_choose_miss: assert property (inv && op == 3'h4 && !own |=> inv)
    else $error("choose miss");
  chk_id_held: assert property ($past(rstn) && op == 3'h0 |=> $stable(session_tag_number))
    else $error("id moved");
  cover property (inv && op == 3'h3 ##1 answer.valid);
  cover property (inv && op == 3'h2 ##1 answer.valid);
  cover property (tag_state == 3'h2);
endmodule
bind tag_anticollision_sequence tag_anticollision_sequence_assertions u_chk (
  .core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd), .answer(answer),
  .tag_state(tag_state), .session_tag_number(session_tag_number));

// >>> verif/reader_model.sv
// Reader coupler model sending decoded commands.
// Assumes the bench orders the round.
`timescale 1ns/10ps
module reader_model (
  // Clock
  input wire logic core_clk,
  // Command
  output logic cmd_valid,
  output anticoll_pkg::cmd_t cmd
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // Fields inverted when idle so a stale command never looks fresh
  task automatic send(input logic [2:0] op, input logic [3:0] sn, input logic [7:0] id);
    @(posedge core_clk);
    #1 cmd_valid = 1'b1;
    cmd = {op, sn, id};
    @(posedge core_clk);
    #1 cmd_valid = 1'b0;
    cmd = ~cmd;
  endtask
endmodule

// >>> verif/tag_anticollision_sequence_bench.sv
// Bench for the tag block, seeded random rounds.
// Assumes reader_model drives commands.
`timescale 1ns/10ps
module tag_anticollision_sequence_bench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid;
  anticoll_pkg::cmd_t cmd;
  anticoll_pkg::answer_t answer;
  logic [2:0] tag_state;
  logic [7:0] session_tag_number;
  logic [31:0] rnd = 32'hB3E195CB;
  logic [7:0] id;
  int fails = 0;
  int checks = 0;
  always #10 core_clk = ~core_clk;
  reader_model u_rdr (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd(cmd));
  tag_anticollision_sequence #(.SEED(16'h5A3C)) u_dut (.core_clk(core_clk), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd(cmd), .answer(answer), .tag_state(tag_state),
    .session_tag_number(session_tag_number));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    for (int r = 0; r < 12; r++) begin
      rnd = xs(rnd);
      rstn = 1'b1;
      u_rdr.send(3'h3, rnd[3:0], 8'h00);
      check({answer.valid, tag_state}, 4'h0);
      u_rdr.send(3'h1, 4'h0, 8'h00);
      id = session_tag_number;
      check({answer.valid, tag_state, answer.session_tag_number}, {4'h9, id});
      u_rdr.send(3'h2, 4'h0, 8'h00);
      check({answer.valid, session_tag_number[7:4]}, {~|session_tag_number[3:0], id[7:4]});
      for (int n = 1; n < 16; n++) begin
        u_rdr.send(3'h3, 4'(n), 8'h00);
        check(answer.valid, 4'(n) == session_tag_number[3:0]);
        if (answer.valid) check(answer.session_tag_number, session_tag_number);
      end
      u_rdr.send(3'h2, 4'h0, 8'h00);
      check(session_tag_number[7:4], id[7:4]);
      u_rdr.send(3'h4, 4'h0, session_tag_number ^ {rnd[7:1], 1'b1});
      check(tag_state, 3'h1);
      u_rdr.send(3'h4, 4'h0, session_tag_number);
      check(tag_state, 3'h2);
      check(answer.valid, 1'b0);
      u_rdr.send(3'h2, 4'h0, 8'h00);
      check({answer.valid, tag_state}, 4'h2);
      u_rdr.send(3'h4, 4'h0, session_tag_number ^ 8'h80);
      check(tag_state, 3'h3);
      u_rdr.send(3'h4, 4'h0, session_tag_number);
      check(tag_state, 3'h2);
      u_rdr.send(3'h5, 4'h0, 8'h00);
      check(tag_state, 3'h4);
      u_rdr.send(3'h1, 4'h0, 8'h00);
      check({answer.valid, tag_state}, 4'h4);
      rstn = 1'b0;
      @(posedge core_clk);
      #1 check({tag_state, session_tag_number}, 11'h0);
    end
    finish_test;
  end
endmodule
